// file: sim/ces_tx_model.sv
`timescale 1ns/1ns
// ========
// Transmitter model. Ready moves only after a rising edge, so it
// never races the bench, which drives on the falling edge.
module ces_tx_model
(
    // Clock.
    input wire logic clock,
    // Egress from the scheduler.
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    output logic out_ready,
    // Bench control.
    input wire logic stall
);
    logic [7:0] got [$];
    always @(posedge clock)
    begin
        if (out_valid && out_ready)
            got.push_back(out_data);
        out_ready <= !stall;
    end
endmodule // ces_tx_model

// file: sim/cos_egress_scheduler_test.sv
`timescale 1ns/1ns
// ========
// Bench for the egress scheduler.
module cos_egress_scheduler_test;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic in_valid = 1'b0;
    logic stall = 1'b1;
    logic in_ready, out_valid, out_urgent, out_ready;
    logic [7:0] out_data;
    logic [1:0] out_class;
    logic [15:0] prio_map = 16'hFA50;
    ces_pkg::ces_frame_t in_frame = '0;
    ces_pkg::ces_class_cfg_t cfg [4];
    int bad_count = 0;
    int n_checks = 0;
    logic [7:0] exp_q [$];
    always #4 clock = ~clock;
    ces_egress_sched i_ces_egress_sched (.clock(clock), .rst(rst),
        .cfg(cfg), .prio_map(prio_map), .in_valid(in_valid),
        .in_frame(in_frame), .in_ready(in_ready), .out_valid(out_valid),
        .out_data(out_data), .out_class(out_class),
        .out_urgent(out_urgent), .out_ready(out_ready));
    ces_tx_model i_ces_tx_model (.clock(clock), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready), .stall(stall));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_up();
        bad_count++;
        $display("unexpected at %0t: wait ran out", $time);
        report_and_stop();
    endtask
    task automatic push(input logic [2:0] p, input logic [7:0] d);
        int i;
        @(negedge clock);
        in_valid = 1'b1;
        in_frame = '{prio: p, data: d};
        for (i = 0; in_ready !== 1'b1; i++)
        begin
            if (i == 50)
                give_up();
            @(negedge clock);
        end
        @(negedge clock);
        in_valid = 1'b0;
    endtask
    task automatic wait_valid();
        int i;
        for (i = 0; out_valid !== 1'b1; i++)
        begin
            if (i == 20)
                give_up();
            @(negedge clock);
        end
    endtask
    // Lets the transmitter run until it has taken as many words as listed, then compares count and words.
    task automatic drain(input logic [7:0] exp [$]);
        int i;
        stall = 1'b0;
        for (i = 0; i_ces_tx_model.got.size() < exp.size(); i++)
        begin
            if (i == 200)
                give_up();
            @(negedge clock);
        end
        stall = 1'b1;
        repeat (2) @(negedge clock);
        check(8'(i_ces_tx_model.got.size()), 8'(exp.size()));
        foreach (exp[k])
            check(i_ces_tx_model.got[k], exp[k]);
        i_ces_tx_model.got.delete();
    endtask
    initial
    begin
        foreach (cfg[c])
            cfg[c] = '{quota: 8'h01, latency: 8'h00};
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        for (int p = 0; p < 8; p++)
        begin
            push(p[2:0], p[7:0]);
            wait_valid();
            check({6'h00, out_class}, 8'(p / 2));
            drain('{p[7:0]});
        end
        prio_map = 16'h5555;
        push(3'h7, 8'h77);
        wait_valid();
        check({6'h00, out_class}, 8'h01);
        drain('{8'h77});
        prio_map = 16'hFA50;
        cfg[3].quota = 8'h02;
        push(3'h6, 8'h31);
        push(3'h7, 8'h32);
        push(3'h6, 8'h33);
        push(3'h4, 8'h21);
        push(3'h5, 8'h22);
        drain('{8'h31, 8'h32, 8'h21, 8'h33, 8'h22});
        cfg[3].quota = 8'h00;
        push(3'h6, 8'h31);
        push(3'h6, 8'h32);
        push(3'h6, 8'h33);
        push(3'h4, 8'h21);
        push(3'h6, 8'h34);
        drain('{8'h31, 8'h32, 8'h33, 8'h34, 8'h21});
        cfg[0].latency = 8'h03;
        push(3'h6, 8'h31);
        push(3'h6, 8'h32);
        push(3'h0, 8'h01);
        repeat (1900) @(negedge clock);
        check({7'h00, out_urgent}, 8'h00);
        repeat (2200) @(negedge clock);
        check({7'h00, out_urgent}, 8'h01);
        check({6'h00, out_class}, 8'h00);
        drain('{8'h01, 8'h31, 8'h32});
        cfg[0].latency = 8'h00;
        push(3'h6, 8'h31);
        repeat (8) @(negedge clock);
        push(3'h0, 8'h01);
        repeat (4100) @(negedge clock);
        check({7'h00, out_urgent}, 8'h00);
        drain('{8'h31, 8'h01});
        for (int n = 0; n < 16; n++)
        begin
            push(3'h2, 8'(n));
            exp_q.push_back(8'(n));
        end
        check({7'h00, in_ready}, 8'h00);
        drain(exp_q);
        report_and_stop();
    end
endmodule // cos_egress_scheduler_test

// file: verilog/ces_egress_sched.sv
`timescale 1ns/1ns
`include "ces_params.svh"

// Behaviour
// (RULE1) Each round starts at class 3 and steps down after its quota.
// (RULE2) Quota 1 to 255 sends exactly that many frames per visit.
// (RULE3) Quota zero serves the class until its queue empties.
// (RULE4) Per-class latency limit bounds each frame's wait in its queue.
// (RULE5) Latency limit zero disables the class's waiting timer.
// (RULE6) Latency limit counts 16 microsecond ticks.
// (RULE7) A frame about to expire goes ahead of the quota order.
// (RULE8) Each of eight priorities maps to one of classes 0 to 3.
// (RULE9) Wait measured from enqueue using a prescaled 16 us tick.
module ces_egress_sched
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Configuration.
    input wire ces_pkg::ces_class_cfg_t cfg [`CES_NUM_CLASSES],
    input wire logic [15:0] prio_map,
    // Ingress frames.
    input wire logic in_valid,
    input wire ces_pkg::ces_frame_t in_frame,
    output logic in_ready,
    // Egress to transmitter.
    output logic out_valid,
    output logic [7:0] out_data,
    output logic [1:0] out_class,
    output logic out_urgent,
    input wire logic out_ready
);
    // =====================================================================
    // Tick prescaler.
    logic [`CES_TICK_W-1:0] pre_r;
    logic [`CES_TICK_W-1:0] pre_nxt;
    logic [`CES_STAMP_W-1:0] now_r;
    logic [`CES_STAMP_W-1:0] now_nxt;
    logic tick;

    assign tick = (pre_r == `CES_TICK_W'(`CES_TICK_CYCLES - 1));

    always_comb
    begin
        pre_nxt = tick ? '0 : pre_r + 1'b1; // [RULE9]
        now_nxt = tick ? now_r + 1'b1 : now_r; // [RULE6]
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pre_r <= '0;
            now_r <= '0;
        end
        else
        begin
            pre_r <= pre_nxt;
            now_r <= now_nxt;
        end
    end

    // =====================================================================
    // Class queues: data held per class, stamps in small memories.
    function automatic logic [1:0] map_class(input logic [2:0] p,
                                             input logic [15:0] m);
        map_class = m[p*2 +: 2];
    endfunction

    logic [1:0] in_cls;
    logic [7:0] qd [`CES_NUM_CLASSES][`CES_DEPTH];
    logic [`CES_PTR_W:0] wp_r [`CES_NUM_CLASSES];
    logic [`CES_PTR_W:0] rp_r [`CES_NUM_CLASSES];
    logic [`CES_STAMP_W-1:0] head_stamp [`CES_NUM_CLASSES];
    logic [`CES_NUM_CLASSES-1:0] nonempty;
    logic [`CES_NUM_CLASSES-1:0] urgent;
    logic pop;
    logic [1:0] sel;

    assign in_cls = map_class(in_frame.prio, prio_map); // [RULE8]
    assign in_ready = (wp_r[in_cls] - rp_r[in_cls]) !=
        (`CES_PTR_W+1)'(`CES_DEPTH);

    for (genvar c = 0; c < `CES_NUM_CLASSES; c++)
    begin : g_q
        logic push;
        logic [`CES_STAMP_W-1:0] age;
        assign push = in_valid && in_ready && (in_cls == 2'(c));
        assign nonempty[c] = wp_r[c] != rp_r[c];
        assign age = now_r - head_stamp[c];
        // Flag one tick early so the frame leaves before the limit passes.
        assign urgent[c] = nonempty[c] && (cfg[c].latency != '0) && // [RULE5]
            (age + 1'b1 >= `CES_STAMP_W'(cfg[c].latency)); // [RULE4] [RULE7]

        ces_stamp_mem u_mem
        (
            .clock(clock),
            .wr_en(push),
            .wr_addr(wp_r[c][`CES_PTR_W-1:0]),
            .wr_data(now_r),
            .rd_addr((pop && sel == 2'(c)) ? rp_r[c][`CES_PTR_W-1:0] + 1'b1
                                            : rp_r[c][`CES_PTR_W-1:0]),
            .rd_data(head_stamp[c])
        );

        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                wp_r[c] <= '0;
                rp_r[c] <= '0;
            end
            else
            begin
                if (push)
                begin
                    wp_r[c] <= wp_r[c] + 1'b1;
                end
                if (pop && sel == 2'(c))
                begin
                    rp_r[c] <= rp_r[c] + 1'b1;
                end
            end
        end

        always_ff @(posedge clock)
        begin
            if (push)
            begin
                qd[c][wp_r[c][`CES_PTR_W-1:0]] <= in_frame.data;
            end
        end
    end

    // =====================================================================
    // Scheduler.
    logic [1:0] cur_r;
    logic [1:0] cur_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic any_urgent;
    logic [1:0] urg_cls;

    always_comb
    begin
        any_urgent = 1'b0;
        urg_cls = 2'h0;
        for (int i = 0; i < `CES_NUM_CLASSES; i++)
        begin
            if (urgent[i])
            begin
                any_urgent = 1'b1;
                urg_cls = 2'(i);
            end
        end
    end

    assign sel = any_urgent ? urg_cls : cur_r; // [RULE7]
    assign out_valid = nonempty[sel];
    assign out_data = qd[sel][rp_r[sel][`CES_PTR_W-1:0]];
    assign out_class = sel;
    assign out_urgent = any_urgent;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        cur_nxt = cur_r;
        cnt_nxt = cnt_r;
        if (!any_urgent)
        begin
            if (!nonempty[cur_r])
            begin
                cur_nxt = cur_r - 1'b1; // [RULE1]
                cnt_nxt = '0;
            end
            else if (pop)
            begin
                if (cfg[cur_r].quota != '0 &&
                    cnt_r + 1'b1 >= cfg[cur_r].quota) // [RULE2]
                begin
                    cur_nxt = cur_r - 1'b1; // [RULE1]
                    cnt_nxt = '0;
                end
                else
                begin
                    cnt_nxt = (cfg[cur_r].quota == '0) ? '0 // [RULE3]
                                                       : cnt_r + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cur_r <= 2'h3;
            cnt_r <= '0;
        end
        else
        begin
            cur_r <= cur_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // =====================================================================
    // Checks.
    a_tick_period: assert property ( // [RULE9]
        @(posedge clock) disable iff (rst) tick |=> !tick)
        else $error("tick too frequent");
    a_urgent_first: assert property ( // [RULE7]
        @(posedge clock) disable iff (rst)
        (urgent != '0) |-> out_urgent && urgent[out_class])
        else $error("urgent class not served");
    a_zero_timer: assert property ( // [RULE5]
        @(posedge clock) disable iff (rst)
        (cfg[0].latency == '0) |-> !urgent[0])
        else $error("disabled timer fired");
    a_quota_step: assert property ( // [RULE2]
        @(posedge clock) disable iff (rst)
        pop && !any_urgent && cfg[cur_r].quota == 8'h01
        |=> cur_r == $past(cur_r) - 2'h1)
        else $error("quota one not honoured");
    a_zero_quota: assert property ( // [RULE3]
        @(posedge clock) disable iff (rst)
        pop && !any_urgent && cfg[cur_r].quota == '0 && nonempty[cur_r]
        |=> cnt_r == '0) else $error("zero quota counted");
    a_empty_down: assert property ( // [RULE1]
        @(posedge clock) disable iff (rst)
        !any_urgent && !nonempty[cur_r] |=> cur_r == $past(cur_r) - 2'h1)
        else $error("empty class not left");
    a_map_class: assert property ( // [RULE8]
        @(posedge clock) disable iff (rst)
        in_cls == prio_map[in_frame.prio*2 +: 2])
        else $error("bad class map");
    a_tick_count: assert property ( // [RULE6]
        @(posedge clock) disable iff (rst)
        tick |=> now_r == $past(now_r) + 1'b1)
        else $error("tick count lost");
    c_urgent: cover property (@(posedge clock) pop && out_urgent);
    c_quota_wrap: cover property (@(posedge clock) pop && cur_r == 2'h0);
    c_full: cover property (@(posedge clock) in_valid && !in_ready);
endmodule // ces_egress_sched

// file: verilog/ces_params.svh
`ifndef CES_PARAMS_SVH
`define CES_PARAMS_SVH

`define CES_NUM_CLASSES 4
`define CES_NUM_PRIO 8
`define CES_CLOCK_MHZ 125
`define CES_TICK_US 16
`define CES_TICK_CYCLES (`CES_TICK_US * `CES_CLOCK_MHZ)
`define CES_TICK_W 11
`define CES_QUOTA_W 8
`define CES_LAT_W 8
`define CES_DEPTH 16
`define CES_PTR_W 4
`define CES_STAMP_W 16
`define CES_PRIO_MAP_RESET 16'hFA50

`endif

// file: verilog/ces_pkg.sv
package ces_pkg;
    typedef enum logic [1:0] {
        CES_IDLE,
        CES_SEND
    } ces_state_t;

    typedef struct packed {
        logic [2:0] prio;
        logic [7:0] data;
    } ces_frame_t;

    typedef struct packed {
        logic [7:0] quota;
        logic [7:0] latency;
    } ces_class_cfg_t;
endpackage

// file: verilog/ces_stamp_mem.sv
`timescale 1ns/1ns
`include "ces_params.svh"

module ces_stamp_mem
(
    // Clock.
    input wire logic clock,
    // Write side.
    input wire logic wr_en,
    input wire logic [`CES_PTR_W-1:0] wr_addr,
    input wire logic [`CES_STAMP_W-1:0] wr_data,
    // Read side.
    input wire logic [`CES_PTR_W-1:0] rd_addr,
    output logic [`CES_STAMP_W-1:0] rd_data
);
    logic [`CES_STAMP_W-1:0] mem [`CES_DEPTH];

    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        // Write-first: a frame pushed into an empty queue must not age on
        // a stale stamp for one cycle.
        rd_data <= (wr_en && wr_addr == rd_addr) ? wr_data : mem[rd_addr];
    end
endmodule // ces_stamp_mem
